// ===== hdl/scir_dev_end.sv
// bridging and relaying monitor device end of the isolated chain
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "scir_regs.svh"
module scir_dev_end #(
  parameter int FRAME_W     = `SCIR_FRAME_W,
  parameter int ISO_BIT_CYC = `SCIR_ISO_BIT_CYC
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // host side link
  scir_link_if.dev_mp link,
  // lower isolated port, used as node
  input  wire logic lower_iso_rx_bit,
  input  wire logic lower_iso_rx_en,
  output logic      lower_iso_tx_bit,
  output logic      lower_iso_tx_en,
  // upper isolated port
  input  wire logic upper_iso_rx_bit,
  input  wire logic upper_iso_rx_en,
  output logic      upper_iso_tx_bit,
  output logic      upper_iso_tx_en,
  // supply monitors and fault line
  input  wire logic fault_in_high_side,
  input  wire logic comm_regulator_ov,
  input  wire logic comm_regulator_uv,
  input  wire logic ref_regulator_ov,
  input  wire logic ref_regulator_uv,
  input  wire logic main_regulator_uv,
  input  wire logic stack_supply_fault,
  // routine requests from monitor logic
  input  wire logic conv_req,
  input  wire logic coulomb_req,
  input  wire logic balance_req,
  // mode and routine status
  output logic       relay_mode,
  output logic       sleep_state,
  output logic       tx_amp_high,
  output logic       conv_enable,
  output logic       coulomb_enable,
  output logic       balance_enable,
  output logic [3:0] fault_flags
);
  localparam int CW = $clog2(FRAME_W + 1);
  localparam int TW = $clog2(ISO_BIT_CYC + 1);

  // ----------------------------------------------------------------
  // configuration state
  // ----------------------------------------------------------------
  logic relay_mode_request_q;
  logic relay_mode_confirm_q;
  logic amp_q;
  wire  relay_on = relay_mode_request_q & relay_mode_confirm_q;
  wire  spi_mode = relay_on | link.port_select_pin;

  // ----------------------------------------------------------------
  // spi slave receive
  // ----------------------------------------------------------------
  logic               sck_q;
  logic               ncs_q;
  logic [FRAME_W-1:0] rsh_q;
  logic [CW-1:0]      rcnt_q;
  wire  sck_rise  = link.sck & ~sck_q;
  wire  sck_fall  = ~link.sck & sck_q;
  wire  ncs_fall  = ~link.ncs & ncs_q;
  wire  ncs_rise  = link.ncs & ~ncs_q;
  wire  sel_act   = spi_mode & ~link.ncs;
  wire  frame_ok  = spi_mode & ncs_rise & (rcnt_q == CW'(FRAME_W));
  wire  is_cfg    = rsh_q[`SCIR_CFG_FLAG];
  wire  fw_load   = frame_ok & ~is_cfg;
  wire  cfg_load  = frame_ok & is_cfg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sck_q  <= 1'b0;
      ncs_q  <= 1'b1;
      rsh_q  <= '0;
      rcnt_q <= '0;
    end else begin
      sck_q <= link.sck;
      ncs_q <= link.ncs;
      if (ncs_fall) begin
        rcnt_q <= '0;
      end else if (sel_act && sck_rise) begin
        rsh_q <= {rsh_q[FRAME_W-2:0], link.sdi};
        if (rcnt_q != CW'(FRAME_W)) begin
          rcnt_q <= rcnt_q + CW'(1);
        end
      end
    end
  end

  // config frames stay local, all others go up the chain
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      relay_mode_request_q <= 1'b0;
      relay_mode_confirm_q <= 1'b0;
      amp_q                <= 1'b0;
    end else if (cfg_load) begin
      relay_mode_request_q <= rsh_q[`SCIR_CFG_REQ];
      relay_mode_confirm_q <= rsh_q[`SCIR_CFG_CONF];
      amp_q                <= rsh_q[`SCIR_CFG_AMP];
    end
  end

  // ----------------------------------------------------------------
  // upper link transmit and receive
  // ----------------------------------------------------------------
  logic ser_bit;
  logic ser_en;

  scir_ser #(
    .W       (FRAME_W),
    .BIT_CYC (ISO_BIT_CYC)
  ) u_ser (
    .ref_clk (ref_clk),
    .rst     (rst),
    .load    (fw_load),
    .word    (rsh_q),
    .tx_bit  (ser_bit),
    .tx_en   (ser_en)
  );

  logic               uen_q;
  logic [TW-1:0]      utm_q;
  logic [FRAME_W-1:0] ush_q;
  logic [CW-1:0]      ucnt_q;
  logic [FRAME_W-1:0] rx_hold_q;
  wire  u_mid  = upper_iso_rx_en && (utm_q == TW'(ISO_BIT_CYC / 2));
  wire  u_wrap = utm_q == TW'(ISO_BIT_CYC - 1);
  wire  u_end  = uen_q & ~upper_iso_rx_en;

  // sampling mid bit keeps a little slack against edge jitter on the link
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      uen_q     <= 1'b0;
      utm_q     <= '0;
      ush_q     <= '0;
      ucnt_q    <= '0;
      rx_hold_q <= '0;
    end else begin
      uen_q <= upper_iso_rx_en;
      if (!upper_iso_rx_en || u_wrap) begin
        utm_q <= '0;
      end else begin
        utm_q <= utm_q + TW'(1);
      end
      if (upper_iso_rx_en && !uen_q) begin
        ucnt_q <= '0;
      end else if (u_mid && ucnt_q != CW'(FRAME_W)) begin
        ush_q  <= {ush_q[FRAME_W-2:0], upper_iso_rx_bit};
        ucnt_q <= ucnt_q + CW'(1);
      end
      if (u_end && spi_mode && ucnt_q == CW'(FRAME_W)) begin
        rx_hold_q <= ush_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // spi slave reply
  // ----------------------------------------------------------------
  logic [FRAME_W-1:0] tsh_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tsh_q <= '0;
    end else if (ncs_fall) begin
      tsh_q <= spi_mode ? rx_hold_q : '0;
    end else if (sel_act && sck_fall) begin
      tsh_q <= {tsh_q[FRAME_W-2:0], 1'b0};
    end
  end

  assign link.sdo = tsh_q[FRAME_W-1];

  // ----------------------------------------------------------------
  // regeneration and port routing
  // ----------------------------------------------------------------
  // one register stage keeps relay delay far below one bit period
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      upper_iso_tx_bit <= 1'b0;
      upper_iso_tx_en  <= 1'b0;
      lower_iso_tx_bit <= 1'b0;
      lower_iso_tx_en  <= 1'b0;
    end else begin
      upper_iso_tx_bit <= spi_mode ? ser_bit : lower_iso_rx_bit;
      upper_iso_tx_en  <= spi_mode ? ser_en : lower_iso_rx_en;
      lower_iso_tx_bit <= spi_mode ? 1'b0 : upper_iso_rx_bit;
      lower_iso_tx_en  <= spi_mode ? 1'b0 : upper_iso_rx_en;
    end
  end

  // ----------------------------------------------------------------
  // faults, routines and sleep
  // ----------------------------------------------------------------
  logic fault_out_q;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fault_flags    <= 4'h0;
      fault_out_q    <= 1'b0;
      relay_mode     <= 1'b0;
      sleep_state    <= 1'b0;
      tx_amp_high    <= 1'b0;
      conv_enable    <= 1'b0;
      coulomb_enable <= 1'b0;
      balance_enable <= 1'b0;
    end else begin
      fault_flags[0] <= comm_regulator_ov | comm_regulator_uv;
      fault_flags[1] <= ref_regulator_ov | ref_regulator_uv;
      fault_flags[2] <= main_regulator_uv & ~relay_on;
      fault_flags[3] <= stack_supply_fault & ~relay_on;
      fault_out_q    <= relay_on ? fault_in_high_side : (|fault_flags);
      relay_mode     <= relay_on;
      sleep_state    <= relay_on & ~link.wake_input_pin;
      tx_amp_high    <= amp_q;
      conv_enable    <= conv_req & ~relay_on;
      coulomb_enable <= coulomb_req & ~relay_on;
      balance_enable <= balance_req & ~relay_on;
    end
  end

  assign link.fault_out_low_side = fault_out_q;
endmodule : scir_dev_end

// ===== hdl/scir_host_end.sv
// host controller end: spi master with frame gap and register port
`timescale 1ns/10ps
`include "scir_regs.svh"
module scir_host_end #(
  parameter int FRAME_W      = `SCIR_FRAME_W,
  parameter int SPI_HALF_CYC = `SCIR_SPI_HALF_CYC,
  parameter int GAP_FAST_CYC = `SCIR_GAP_FAST_CYC,
  parameter int GAP_SLOW_CYC = `SCIR_GAP_SLOW_CYC
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // device link
  scir_link_if.host_mp     link,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // interrupt
  output logic             irq
);
  localparam int CW = $clog2(FRAME_W + 1);
  localparam int HW = $clog2(SPI_HALF_CYC + 1);

  scir_pkg::scir_hst_state_type st_q;
  logic [2:0]                   ctrl_q;
  logic [`SCIR_STAT_W-1:0]      stat_q;
  logic [`SCIR_STAT_W-1:0]      en_q;
  logic [FRAME_W-1:0]           rx_q;
  logic [FRAME_W-1:0]           tsh_q;
  logic [FRAME_W-1:0]           rsh_q;
  logic [CW-1:0]                bits_q;
  logic [HW-1:0]                div_q;
  logic [31:0]                  gap_q;
  logic [31:0]                  gap_lat_q;
  logic                         sck_q;
  logic                         ncs_q;
  logic                         mosi_q;
  logic                         flt_q;
  logic [FRAME_W-1:0]           cfg_word;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire send_req  = wr & ((addr == `SCIR_OFS_TX) | (addr == `SCIR_OFS_CFG));
  wire idle      = (st_q == scir_pkg::hst_idle);
  wire start     = send_req & idle;
  wire drop_evt  = send_req & ~idle;
  wire half_done = (div_q == HW'(SPI_HALF_CYC - 1));
  wire last_fall = (st_q == scir_pkg::hst_xfer) & half_done & sck_q &
                   (bits_q == CW'(FRAME_W));
  wire gap_done  = (st_q == scir_pkg::hst_gap) & (gap_q >= gap_lat_q - 32'd1);
  wire flt_evt   = link.fault_out_low_side & ~flt_q;
  wire [`SCIR_STAT_W-1:0] evt = {drop_evt, flt_evt, last_fall};
  wire [FRAME_W-1:0] tx_word = (addr == `SCIR_OFS_CFG) ? cfg_word : wdata[FRAME_W-1:0];

  // config frame sets request and confirm together from software bits
  always_comb begin
    cfg_word                 = '0;
    cfg_word[`SCIR_CFG_FLAG] = 1'b1;
    cfg_word[`SCIR_CFG_REQ]  = wdata[`SCIR_CFG_REQ];
    cfg_word[`SCIR_CFG_CONF] = wdata[`SCIR_CFG_CONF];
    cfg_word[`SCIR_CFG_AMP]  = wdata[`SCIR_CFG_AMP];
  end

  // ----------------------------------------------------------------
  // frame engine
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q      <= scir_pkg::hst_idle;
      sck_q     <= 1'b0;
      ncs_q     <= 1'b1;
      mosi_q    <= 1'b0;
      tsh_q     <= '0;
      rsh_q     <= '0;
      rx_q      <= '0;
      bits_q    <= '0;
      div_q     <= '0;
      gap_q     <= 32'd0;
      gap_lat_q <= 32'd1;
    end else begin
      unique case (st_q)
        scir_pkg::hst_idle: begin
          if (start) begin
            st_q      <= scir_pkg::hst_xfer;
            ncs_q     <= 1'b0;
            tsh_q     <= tx_word;
            mosi_q    <= tx_word[FRAME_W-1];
            bits_q    <= '0;
            div_q     <= '0;
            // gap of the mode this frame runs in, even if mode changes later
            gap_lat_q <= ctrl_q[`SCIR_CTRL_SLOW] ? 32'(GAP_SLOW_CYC)
                                                 : 32'(GAP_FAST_CYC);
          end
        end
        scir_pkg::hst_xfer: begin
          div_q <= half_done ? '0 : div_q + HW'(1);
          if (half_done) begin
            sck_q <= ~sck_q;
            if (!sck_q) begin
              rsh_q  <= {rsh_q[FRAME_W-2:0], link.sdo};
              bits_q <= bits_q + CW'(1);
            end else if (last_fall) begin
              ncs_q <= 1'b1;
              rx_q  <= rsh_q;
              gap_q <= 32'd0;
              st_q  <= scir_pkg::hst_gap;
            end else begin
              tsh_q  <= {tsh_q[FRAME_W-2:0], 1'b0};
              mosi_q <= tsh_q[FRAME_W-2];
            end
          end
        end
        scir_pkg::hst_gap: begin
          gap_q <= gap_q + 32'd1;
          if (gap_done) begin
            st_q <= scir_pkg::hst_idle;
          end
        end
        default: begin
          st_q <= scir_pkg::hst_idle;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `SCIR_CTRL_RST;
      en_q   <= '0;
      stat_q <= '0;
      flt_q  <= 1'b0;
      irq    <= 1'b0;
      rdata  <= 32'h0;
    end else begin
      flt_q <= link.fault_out_low_side;
      if (wr && addr == `SCIR_OFS_CTRL) begin
        ctrl_q <= wdata[2:0];
      end
      if (wr && addr == `SCIR_OFS_EN) begin
        en_q <= wdata[`SCIR_STAT_W-1:0];
      end
      // a new event wins over a clear in the same cycle
      if (wr && addr == `SCIR_OFS_CLR) begin
        stat_q <= (stat_q & ~wdata[`SCIR_STAT_W-1:0]) | evt;
      end else begin
        stat_q <= stat_q | evt;
      end
      irq <= |(stat_q & en_q);
      if (!rd) begin
        rdata <= 32'h0;
      end else if (addr == `SCIR_OFS_CTRL) begin
        rdata <= {29'h0, ctrl_q};
      end else if (addr == `SCIR_OFS_RX) begin
        rdata <= 32'(rx_q);
      end else if (addr == `SCIR_OFS_STAT) begin
        rdata <= 32'(stat_q);
      end else if (addr == `SCIR_OFS_EN) begin
        rdata <= 32'(en_q);
      end else begin
        rdata <= 32'h0;
      end
    end
  end

  assign link.sck             = sck_q;
  assign link.ncs             = ncs_q;
  assign link.sdi             = mosi_q;
  assign link.port_select_pin = ctrl_q[`SCIR_CTRL_PSEL];
  assign link.wake_input_pin  = ctrl_q[`SCIR_CTRL_WAKE];
endmodule : scir_host_end

// ===== hdl/scir_link_if.sv
// host spi link between controller and bridging device
`timescale 1ns/10ps
interface scir_link_if;
  logic sck;
  logic ncs;
  logic sdi;
  logic sdo;
  logic port_select_pin;
  logic wake_input_pin;
  logic fault_out_low_side;

  modport dev_mp (
    input  sck, ncs, sdi, port_select_pin, wake_input_pin,
    output sdo, fault_out_low_side
  );
  modport host_mp (
    output sck, ncs, sdi, port_select_pin, wake_input_pin,
    input  sdo, fault_out_low_side
  );
endinterface : scir_link_if

// ===== hdl/scir_pkg.sv
// types used by the host end of the isolated chain relay
package scir_pkg;
  typedef enum logic [1:0] {
    hst_idle = 2'b00,
    hst_xfer = 2'b01,
    hst_gap  = 2'b10
  } scir_hst_state_type;
endpackage : scir_pkg

// ===== hdl/scir_regs.svh
// constants shared by both ends of the isolated chain relay
`ifndef SCIR_REGS_SVH
`define SCIR_REGS_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define SCIR_FRAME_W      16
`define SCIR_CFG_FLAG     15
`define SCIR_CFG_REQ      0
`define SCIR_CFG_CONF     1
`define SCIR_CFG_AMP      2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SCIR_CLK_NS       4
`define SCIR_ISO_BIT_NS   376
`define SCIR_ISO_BIT_CYC  (`SCIR_ISO_BIT_NS / `SCIR_CLK_NS)
`define SCIR_SPI_HALF_CYC 4
`define SCIR_GAP_FAST_NS  60000
`define SCIR_GAP_SLOW_NS  425000
`define SCIR_GAP_FAST_CYC ((`SCIR_GAP_FAST_NS + `SCIR_CLK_NS - 1) / `SCIR_CLK_NS)
`define SCIR_GAP_SLOW_CYC ((`SCIR_GAP_SLOW_NS + `SCIR_CLK_NS - 1) / `SCIR_CLK_NS)

// ----------------------------------------------------------------
// host controller register map
// ----------------------------------------------------------------
`define SCIR_OFS_CTRL     8'h00
`define SCIR_OFS_TX       8'h04
`define SCIR_OFS_CFG      8'h08
`define SCIR_OFS_RX       8'h0c
`define SCIR_OFS_STAT     8'h10
`define SCIR_OFS_CLR      8'h14
`define SCIR_OFS_EN       8'h18
`define SCIR_CTRL_PSEL    0
`define SCIR_CTRL_WAKE    1
`define SCIR_CTRL_SLOW    2
`define SCIR_CTRL_RST     3'h0
`define SCIR_STAT_DONE    0
`define SCIR_STAT_FAULT   1
`define SCIR_STAT_DROP    2
`define SCIR_STAT_W       3

`endif

// ===== hdl/scir_ser.sv
// word serializer driving the isolated link bit stream
`timescale 1ns/10ps
`include "scir_regs.svh"
module scir_ser #(
  parameter int W       = `SCIR_FRAME_W,
  parameter int BIT_CYC = `SCIR_ISO_BIT_CYC
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // word in
  input  wire logic         load,
  input  wire logic [W-1:0] word,
  // bit stream out
  output logic              tx_bit,
  output logic              tx_en
);
  localparam int CW = $clog2(W + 1);
  localparam int TW = $clog2(BIT_CYC + 1);

  logic [W-1:0]  sh_q;
  logic [CW-1:0] left_q;
  logic [TW-1:0] tm_q;
  wire           busy     = (left_q != '0);
  wire           bit_end  = busy && (tm_q == TW'(BIT_CYC - 1));

  // a load during a frame is dropped; the host gap keeps it from happening
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sh_q   <= '0;
      left_q <= '0;
      tm_q   <= '0;
    end else if (load && !busy) begin
      sh_q   <= word;
      left_q <= CW'(W);
      tm_q   <= '0;
    end else if (bit_end) begin
      sh_q   <= {sh_q[W-2:0], 1'b0};
      left_q <= left_q - CW'(1);
      tm_q   <= '0;
    end else if (busy) begin
      tm_q   <= tm_q + TW'(1);
    end
  end

  assign tx_bit = sh_q[W-1];
  assign tx_en  = busy;
endmodule : scir_ser

// ===== sim/scir_properties.sv
// protocol checker watching the host link between controller and device
`timescale 1ns/10ps
module scir_properties #(
  parameter int GAP = 20
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // host link
  input wire logic sck,
  input wire logic ncs,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic port_select_pin,
  input wire logic wake_input_pin,
  input wire logic fault_out_low_side
);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  logic       sck_q;
  logic [4:0] rise_q;
  logic [7:0] high_q;
  // high_q saturates so a long idle never wraps below the gap
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sck_q  <= 1'b0;
      rise_q <= 5'h00;
      high_q <= 8'hff;
    end else begin
      sck_q  <= sck;
      rise_q <= ncs ? 5'h00 : rise_q + 5'(sck & ~sck_q);
      high_q <= !ncs ? 8'h00 : ((high_q == 8'hff) ? high_q : high_q + 8'h01);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_idle_sck_low: assert property (ncs |-> !sck)
    else $error("clock moved outside a frame");
  chk_sck_high_half: assert property ($rose(sck) |-> sck[*4] ##1 !sck)
    else $error("clock high phase wrong");
  chk_sck_low_half: assert property ($fell(sck) |-> !sck[*4])
    else $error("clock low phase wrong");
  chk_select_lead: assert property ($fell(ncs) |-> !sck[*4])
    else $error("clock rose too soon after select");
  chk_frame_bits: assert property ($rose(ncs) |-> rise_q == 5'h10)
    else $error("frame without sixteen clocks");
  chk_frame_close: assert property (rise_q == 5'h10 && $fell(sck) |-> ##[0:8] ncs)
    else $error("frame not closed after last bit");
  chk_sdi_settled: assert property (!ncs && $rose(sck) |-> $stable(sdi))
    else $error("host data moved at sampling edge");
  chk_frame_gap: assert property ($fell(ncs) |-> high_q >= 8'(GAP))
    else $error("frame gap too short");

  cov_frame: cover property ($rose(ncs));
  cov_fault: cover property ($rose(fault_out_low_side) && !sdo);
  cov_sleep: cover property ($fell(wake_input_pin) && !port_select_pin);
endmodule : scir_properties

// ===== sim/testbench.sv
// self-checking bench: host controller and device joined by the link
`timescale 1ns/10ps
`include "scir_regs.svh"
module testbench;
  logic        ref_clk, rst, wr, rd, rd_d, irq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic        lo_bit, lo_en, up_bit, up_en, lo_tx_bit, lo_tx_en, up_tx_bit, up_tx_en;
  logic        flt_in, c_ov, c_uv, r_ov, r_uv, m_uv, stk, conv_r, coul_r, bal_r;
  logic        relay, sleep, amp, conv_e, coul_e, bal_e;
  logic [3:0]  flags;
  logic [31:0] exp_q[$];
  logic [15:0] w;
  int          mismatches, n_tests;

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  scir_link_if lnk ();
  scir_host_end #(.GAP_FAST_CYC(20), .GAP_SLOW_CYC(50)) u_scir_host_end (
    .ref_clk(ref_clk), .rst(rst), .link(lnk), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
  scir_dev_end #(.ISO_BIT_CYC(8)) u_scir_dev_end (
    .ref_clk(ref_clk), .rst(rst), .link(lnk),
    .lower_iso_rx_bit(lo_bit), .lower_iso_rx_en(lo_en),
    .lower_iso_tx_bit(lo_tx_bit), .lower_iso_tx_en(lo_tx_en),
    .upper_iso_rx_bit(up_bit), .upper_iso_rx_en(up_en),
    .upper_iso_tx_bit(up_tx_bit), .upper_iso_tx_en(up_tx_en),
    .fault_in_high_side(flt_in), .comm_regulator_ov(c_ov), .comm_regulator_uv(c_uv),
    .ref_regulator_ov(r_ov), .ref_regulator_uv(r_uv), .main_regulator_uv(m_uv),
    .stack_supply_fault(stk), .conv_req(conv_r), .coulomb_req(coul_r),
    .balance_req(bal_r), .relay_mode(relay), .sleep_state(sleep), .tx_amp_high(amp),
    .conv_enable(conv_e), .coulomb_enable(coul_e), .balance_enable(bal_e),
    .fault_flags(flags));
  scir_properties #(.GAP(20)) u_scir_properties (
    .ref_clk(ref_clk), .rst(rst), .sck(lnk.sck), .ncs(lnk.ncs), .sdi(lnk.sdi),
    .sdo(lnk.sdo), .port_select_pin(lnk.port_select_pin),
    .wake_input_pin(lnk.wake_input_pin), .fault_out_low_side(lnk.fault_out_low_side));

  // ----------------------------------------------------------------
  // checking and reporting
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("TB: mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk) rd_d <= rd;
  always @(negedge ref_clk) begin
    if (rd_d === 1'b1) chk(rdata, exp_q.pop_front());
  end

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk);
    rd   <= 1'b0;
  endtask : rd_reg

  // waits out the frame in flight and the longest gap after it
  task automatic wait_frame();
    int k;
    k = 0;
    while (lnk.ncs !== 1'b0 && k < 50) begin
      @(posedge ref_clk);
      k++;
    end
    while (lnk.ncs !== 1'b1 && k < 400) begin
      @(posedge ref_clk);
      k++;
    end
    if (k == 50 || k >= 400) begin
      mismatches++;
      $display("ERROR t=%0t wait bound hit %h %h", $time, k, 400);
      results();
    end
    repeat (60) @(posedge ref_clk);
  endtask : wait_frame

  task automatic frame(input logic [7:0] a, input logic [31:0] d);
    wr_reg(a, d);
    wait_frame();
  endtask : frame

  task automatic up_send(input logic [15:0] v);
    for (int i = 15; i >= 0; i--) begin
      @(posedge ref_clk);
      up_en  <= 1'b1;
      up_bit <= v[i];
      repeat (7) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    up_en <= 1'b0;
  endtask : up_send

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int k;
    {rst, wr, rd, addr, wdata, lo_bit, lo_en, up_bit, up_en} = {2'b10, 1'b0, 8'h00, 36'h0};
    {flt_in, c_ov, c_uv, r_ov, r_uv, m_uv, stk, conv_r, coul_r, bal_r} = 10'h000;
    mismatches = 0;
    n_tests    = 0;
    void'($urandom(32'h0b171de7));
    w = 16'($urandom) & 16'h7fff;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd_reg(`SCIR_OFS_CTRL, 32'h0);
    rd_reg(8'h1c, 32'h0);
    wr_reg(`SCIR_OFS_CTRL, 32'h3);
    rd_reg(`SCIR_OFS_CTRL, 32'h3);
    $display("test 1 registers done");
    conv_r <= 1'b1;
    coul_r <= 1'b1;
    bal_r  <= 1'b1;
    frame(`SCIR_OFS_CFG, 32'h1);
    chk(relay, 1'b0);
    chk(conv_e & coul_e & bal_e, 1'b1);
    // second order lands while the first frame runs and must be dropped
    wr_reg(`SCIR_OFS_TX, {16'h0, w});
    wr_reg(`SCIR_OFS_CFG, 32'h3);
    wait_frame();
    chk(relay, 1'b0);
    rd_reg(`SCIR_OFS_STAT, 32'h5);
    wr_reg(`SCIR_OFS_CLR, 32'h7);
    rd_reg(`SCIR_OFS_STAT, 32'h0);
    $display("test 2 partial config and refusal done");
    frame(`SCIR_OFS_CFG, 32'h3);
    chk(relay, 1'b1);
    chk({conv_e, coul_e, bal_e}, 3'b000);
    chk(sleep, 1'b0);
    wr_reg(`SCIR_OFS_CTRL, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk(sleep, 1'b1);
    wr_reg(`SCIR_OFS_TX, {16'h0, w});
    k = 0;
    while (up_tx_en !== 1'b1 && k < 400) begin
      @(posedge ref_clk);
      k++;
    end
    chk(k < 400, 1'b1);
    repeat (4) @(posedge ref_clk);
    for (int i = 15; i >= 0; i--) begin
      chk(up_tx_bit, w[i]);
      chk(lo_tx_en, 1'b0);
      repeat (8) @(posedge ref_clk);
    end
    repeat (60) @(posedge ref_clk);
    $display("test 3 relay entry and upward frame done");
    flt_in <= 1'b1;
    c_ov   <= 1'b1;
    m_uv   <= 1'b1;
    stk    <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(lnk.fault_out_low_side, 1'b1);
    chk(flags, 4'h1);
    wr_reg(`SCIR_OFS_EN, 32'h2);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b1);
    wr_reg(`SCIR_OFS_EN, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
    rd_reg(`SCIR_OFS_STAT, 32'h3);
    wr_reg(`SCIR_OFS_CLR, 32'h3);
    rd_reg(`SCIR_OFS_STAT, 32'h0);
    {flt_in, c_ov, stk} <= 3'b000;
    $display("test 4 fault relay and interrupt done");
    wr_reg(`SCIR_OFS_CTRL, 32'h3);
    up_send(~w);
    frame(`SCIR_OFS_TX, 32'h0);
    rd_reg(`SCIR_OFS_RX, {16'h0, ~w});
    frame(`SCIR_OFS_CFG, 32'h4);
    chk({relay, amp, conv_e}, 3'b011);
    chk(flags, 4'h4);
    wr_reg(`SCIR_OFS_CTRL, 32'h0);
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      lo_en  <= 1'b1;
      lo_bit <= w[i];
      up_en  <= 1'b1;
      up_bit <= ~w[i];
      @(negedge ref_clk);
      if (i > 0) chk({up_tx_en, up_tx_bit}, {1'b1, w[i - 1]});
      if (i > 0) chk({lo_tx_en, lo_tx_bit}, {1'b1, ~w[i - 1]});
    end
    $display("test 5 relay exit and node regeneration done");
    // slow frame, then fast mode: the next order inside the slow gap is dropped
    wr_reg(`SCIR_OFS_CLR, 32'h7);
    wr_reg(`SCIR_OFS_CTRL, 32'h5);
    wr_reg(`SCIR_OFS_TX, {16'h0, w});
    wr_reg(`SCIR_OFS_CTRL, 32'h1);
    repeat (150) @(posedge ref_clk);
    wr_reg(`SCIR_OFS_TX, {16'h0, w});
    repeat (40) @(posedge ref_clk);
    rd_reg(`SCIR_OFS_STAT, 32'h5);
    $display("test 6 old gap kept after mode change done");
    results();
  end
endmodule : testbench
